// >>> core/ccc_pkg.sv
package ccc_pkg;

    // Byte addresses of the unit's register map.
    localparam logic [31:0] ADDR_CTL      = 32'h4002_1000;
    localparam logic [31:0] ADDR_CFG0     = 32'h4002_1004;
    localparam logic [31:0] ADDR_INT      = 32'h4002_1008;
    localparam logic [31:0] ADDR_PB2_RST  = 32'h4002_100c;
    localparam logic [31:0] ADDR_PB1_RST  = 32'h4002_1010;
    localparam logic [31:0] ADDR_HB_CEN   = 32'h4002_1014;
    localparam logic [31:0] ADDR_PB2_CEN  = 32'h4002_1018;
    localparam logic [31:0] ADDR_PB1_CEN  = 32'h4002_101c;
    localparam logic [31:0] ADDR_BD_CTL   = 32'h4002_1020;
    localparam logic [31:0] ADDR_CSR      = 32'h4002_1024;
    localparam logic [31:0] ADDR_HB_RST   = 32'h4002_1028;

    // clock_control fields.
    localparam int CTL_PLL_RDY  = 25;
    localparam int CTL_PLL_EN   = 24;
    localparam int CTL_HSE_LP   = 20;
    localparam int CTL_CSS_EN   = 19;
    localparam int CTL_HSE_BYP  = 18;
    localparam int CTL_HSE_RDY  = 17;
    localparam int CTL_HSE_EN   = 16;
    localparam int CTL_CAL_LO   = 8;
    localparam int CTL_TRIM_LO  = 3;
    localparam int CTL_HSI_LP   = 2;
    localparam int CTL_HSI_RDY  = 1;
    localparam int CTL_HSI_EN   = 0;

    // clock_config_0 fields (low bit of each).
    localparam int CFG_ADC_SEL  = 31;
    localparam int CFG_DUTY_LO  = 28;
    localparam int CFG_MCO_LO   = 24;
    localparam int CFG_USB_LO   = 22;
    localparam int CFG_MUL_LO   = 18;
    localparam int CFG_XTPRE    = 17;
    localparam int CFG_SRC      = 16;
    localparam int CFG_ADCP_LO  = 14;
    localparam int CFG_PB2_LO   = 11;
    localparam int CFG_PB1_LO   = 8;
    localparam int CFG_HB_LO    = 4;
    localparam int CFG_SWS_LO   = 2;
    localparam int CFG_SW_LO    = 0;

    // clock_interrupt fields handled here.
    localparam int INT_CSS_CLR  = 23;
    localparam int INT_CSS_FLAG = 7;

    // Reset values.
    localparam logic [4:0] TRIM_RST     = 5'h10;
    localparam logic       HSE_LP_RST   = 1'b1;
    localparam logic       HSI_EN_RST   = 1'b1;
    localparam logic       HSI_RDY_RST  = 1'b1;

    // Source encodings shared by select and status fields.
    localparam logic [1:0] SRC_HSI = 2'h0;
    localparam logic [1:0] SRC_HSE = 2'h1;
    localparam logic [1:0] SRC_PLL = 2'h2;

    // Oscillator cycles the ready flag lingers after disable.
    localparam int RDY_HOLD_CYCLES = 6;

endpackage

// >>> core/ccc_osc_if.sv
`timescale 1ns/1ps
interface ccc_osc_if;
    logic en;       // Oscillator enable from the register file.
    logic stable;   // Raw oscillator stable indication (pin).
    logic tick;     // Raw oscillator clock (pin), sampled.
    logic ready;    // Ready flag back to the register file.

    modport core
    (
        output en,
        output stable,
        output tick,
        input  ready
    );

    modport trk
    (
        input  en,
        input  stable,
        input  tick,
        output ready
    );
endinterface

// >>> core/ccc_osc_ready.sv
`timescale 1ns/1ps
module ccc_osc_ready #(
    parameter logic RESET_READY = 1'b0
) (
    input  wire logic clk,   // System clock.
    input  wire logic rstn,  // Asynchronous reset, active low.
    ccc_osc_if.trk    osc    // Oscillator controls and ready flag.
);
    typedef struct packed {
        logic [1:0] stb_s;
        logic [1:0] tck_s;
        logic       tck_prev;
        logic [2:0] cnt;
        logic       ready;
    } ccc_rdy_st_t;

    ccc_rdy_st_t st_r;
    ccc_rdy_st_t st_nxt;

    assign osc.ready = st_r.ready;

    // The oscillator clock is far slower than clk in practice, so its
    // rising edges are counted after a two-stage synchroniser.
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.stb_s    = {st_r.stb_s[0], osc.stable};
        st_nxt.tck_s    = {st_r.tck_s[0], osc.tick};
        st_nxt.tck_prev = st_r.tck_s[1];
        if (osc.en)
        begin
            st_nxt.cnt = 3'h0;
            if (st_r.stb_s[1])
            begin
                st_nxt.ready = 1'b1;
            end
        end
        else if (st_r.ready && st_r.tck_s[1] && !st_r.tck_prev)
        begin
            if (st_r.cnt == 3'(ccc_pkg::RDY_HOLD_CYCLES - 1))
            begin
                st_nxt.ready = 1'b0;
                st_nxt.cnt   = 3'h0;
            end
            else
            begin
                st_nxt.cnt = 3'(st_r.cnt + 3'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r       <= '0;
            st_r.ready <= RESET_READY;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// >>> core/ccc_core.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module ccc_core
(
    input  wire logic        clk,            // System clock, 100 MHz.
    input  wire logic        rstn,           // Async reset, active low.
    input  wire logic [31:0] addr,           // Register byte address.
    input  wire logic [31:0] wdata,          // Register write data.
    input  wire logic        wr,             // Write strobe.
    input  wire logic        rd,             // Read strobe.
    output logic      [31:0] rdata,          // Read data, next cycle.
    input  wire logic        lp_enter,       // Stop/Standby entry pulse.
    input  wire logic        lp_exit,        // Stop/Standby wake pulse.
    input  wire logic        pll_locked_pin, // PLL lock indication.
    input  wire logic        hse_fault_pin,  // EXTERNAL_FAST_OSC clock-missing detector.
    input  wire logic        hsi_stable_pin, // INTERNAL_FAST_OSC oscillator settled.
    input  wire logic        hsi_clk_pin,    // INTERNAL_FAST_OSC oscillator clock.
    input  wire logic        hse_stable_pin, // EXTERNAL_FAST_OSC oscillator settled.
    input  wire logic        hse_clk_pin,    // EXTERNAL_FAST_OSC oscillator clock.
    input  wire logic [7:0]  cal_value,      // Factory calibration byte.
    input  wire logic [4:0]  lp_trim_value,  // Stored low-power trim.
    output logic             pll_enable,     // PLL run.
    output logic             ext_osc_enable, // EXTERNAL_FAST_OSC oscillator run.
    output logic             ext_clock_bypass, // EXTERNAL_FAST_OSC bypass mode.
    output logic             ext_osc_low_power, // EXTERNAL_FAST_OSC low-power mode.
    output logic             int_osc_enable, // INTERNAL_FAST_OSC oscillator run.
    output logic             int_osc_low_power, // INTERNAL_FAST_OSC at 1 MHz.
    output logic      [7:0]  int_osc_tune,   // Calibration plus trim.
    output logic      [1:0]  system_clock_source_status, // Active source.
    output logic      [9:0]  hb_div_factor,  // System clock to HCLK.
    output logic      [4:0]  pb1_div_factor, // HCLK to PB1 clock.
    output logic      [4:0]  pb2_div_factor, // HCLK to PB2 clock.
    output logic      [3:0]  adc_div_factor, // PB2 clock to ADC clock.
    output logic             adc_from_hclk,  // ADC clocked by HCLK.
    output logic      [2:0]  adc_duty_extra, // Extra high HCLK cycles.
    output logic      [4:0]  pll_mult_factor, // PLL multiplication.
    output logic             pll_from_ext,   // PLL fed from EXTERNAL_FAST_OSC.
    output logic             pll_ext_halve,  // EXTERNAL_FAST_OSC halved into PLL.
    output logic      [2:0]  usb_div_x2,     // USB divider times two.
    output logic      [3:0]  clkout_sel,     // One-hot sys/hsi/hse/pll2, or zero.
    output logic             clock_security_flag, // EXTERNAL_FAST_OSC failure seen.
    output logic             nmi_req         // Clock failure NMI pulse.
);
    typedef struct packed {
        logic        pll_en;
        logic        hse_en;
        logic        hse_byp;
        logic        hse_lp;
        logic        css_en;
        logic        hsi_en;
        logic        hsi_lp;
        logic [4:0]  trim;
        logic [7:0]  cal;
        logic        cal_done;
        logic        adc_sel;
        logic [2:0]  duty;
        logic [2:0]  mco;
        logic [1:0]  usb;
        logic [3:0]  mul;
        logic        xtpre;
        logic        src;
        logic [1:0]  adcpre;
        logic [2:0]  pb2;
        logic [2:0]  pb1;
        logic [3:0]  hb;
        logic [1:0]  sws;
        logic [1:0]  sw;
        logic        css_flag;
        logic        nmi;
        logic [1:0]  lock_s;
        logic [1:0]  fault_s;
        logic [31:0] rdata;
        logic [7:0]  tune;
        logic [9:0]  hb_fac;
        logic [4:0]  pb1_fac;
        logic [4:0]  pb2_fac;
        logic [3:0]  adc_fac;
        logic [4:0]  mul_fac;
        logic [2:0]  usb_x2;
        logic [3:0]  clkout;
    } ccc_core_st_t;

    ccc_core_st_t st_r;
    ccc_core_st_t st_nxt;

    ccc_osc_if hsi_if ();
    ccc_osc_if hse_if ();

    assign hsi_if.en     = st_r.hsi_en;
    assign hsi_if.stable = hsi_stable_pin;
    assign hsi_if.tick   = hsi_clk_pin;
    assign hse_if.en     = st_r.hse_en;
    assign hse_if.stable = hse_stable_pin;
    assign hse_if.tick   = hse_clk_pin;

    ccc_osc_ready #(
        .RESET_READY (ccc_pkg::HSI_RDY_RST)
    ) u_hsi_ready (
        .clk  (clk),
        .rstn (rstn),
        .osc  (hsi_if.trk)
    );

    ccc_osc_ready #(
        .RESET_READY (1'b0)
    ) u_hse_ready (
        .clk  (clk),
        .rstn (rstn),
        .osc  (hse_if.trk)
    );

    function automatic logic [4:0] pb_factor(input logic [2:0] code);
        pb_factor = code[2] ? 5'(5'h2 << code[1:0]) : 5'h1;
    endfunction

    function automatic logic [9:0] hb_factor(input logic [3:0] code);
        unique case (code)
            4'h8:    hb_factor = 10'h002;
            4'h9:    hb_factor = 10'h004;
            4'ha:    hb_factor = 10'h008;
            4'hb:    hb_factor = 10'h010;
            4'hc:    hb_factor = 10'h040;
            4'hd:    hb_factor = 10'h080;
            4'hf:    hb_factor = 10'h200;
            // Reserved 1110 runs undivided rather than guessing a ratio.
            default: hb_factor = 10'h001;
        endcase
    endfunction

    function automatic logic [3:0] clkout_onehot(input logic [2:0] code);
        clkout_onehot = code[2] ? 4'(4'h1 << code[1:0]) : 4'h0;
    endfunction

    logic        hsi_rdy;
    logic        hse_rdy;
    logic        pll_rdy;
    logic        hse_fail;
    logic        hse_active;
    logic        hit_ctl;
    logic        hit_cfg;
    logic        hit_int;
    logic [1:0]  sw_req;
    logic        sw_target_rdy;
    logic [31:0] ctl_rd;
    logic [31:0] cfg_rd;
    logic [31:0] int_rd;

    assign hsi_rdy = hsi_if.ready;
    assign hse_rdy = hse_if.ready;
    assign pll_rdy = st_r.lock_s[1];
    assign hit_ctl = addr == ccc_pkg::ADDR_CTL;
    assign hit_cfg = addr == ccc_pkg::ADDR_CFG0;
    assign hit_int = addr == ccc_pkg::ADDR_INT;

    // Monitoring is gated by the ready flag so a still starting EXTERNAL_FAST_OSC,
    // or a stopped one once its ready flag has dropped, never reads as a failure.
    assign hse_fail = st_r.fault_s[1] && st_r.css_en && hse_rdy;

    // EXTERNAL_FAST_OSC feeds the system either directly or as the PLL reference.
    assign hse_active = (st_r.sws == ccc_pkg::SRC_HSE)
                     || (st_r.sws == ccc_pkg::SRC_PLL && st_r.src);

    always_comb
    begin
        ctl_rd = '0;
        ctl_rd[ccc_pkg::CTL_PLL_RDY]                  = pll_rdy;
        ctl_rd[ccc_pkg::CTL_PLL_EN]                   = st_r.pll_en;
        ctl_rd[ccc_pkg::CTL_HSE_LP]                   = st_r.hse_lp;
        ctl_rd[ccc_pkg::CTL_CSS_EN]                   = st_r.css_en;
        ctl_rd[ccc_pkg::CTL_HSE_BYP]                  = st_r.hse_byp;
        ctl_rd[ccc_pkg::CTL_HSE_RDY]                  = hse_rdy;
        ctl_rd[ccc_pkg::CTL_HSE_EN]                   = st_r.hse_en;
        ctl_rd[ccc_pkg::CTL_CAL_LO +: 8]              = st_r.cal;
        ctl_rd[ccc_pkg::CTL_TRIM_LO +: 5]             = st_r.trim;
        ctl_rd[ccc_pkg::CTL_HSI_LP]                   = st_r.hsi_lp;
        ctl_rd[ccc_pkg::CTL_HSI_RDY]                  = hsi_rdy;
        ctl_rd[ccc_pkg::CTL_HSI_EN]                   = st_r.hsi_en;
        cfg_rd = '0;
        cfg_rd[ccc_pkg::CFG_ADC_SEL]                  = st_r.adc_sel;
        cfg_rd[ccc_pkg::CFG_DUTY_LO +: 3]             = st_r.duty;
        cfg_rd[ccc_pkg::CFG_MCO_LO +: 3]              = st_r.mco;
        cfg_rd[ccc_pkg::CFG_USB_LO +: 2]              = st_r.usb;
        cfg_rd[ccc_pkg::CFG_MUL_LO +: 4]              = st_r.mul;
        cfg_rd[ccc_pkg::CFG_XTPRE]                    = st_r.xtpre;
        cfg_rd[ccc_pkg::CFG_SRC]                      = st_r.src;
        cfg_rd[ccc_pkg::CFG_ADCP_LO +: 2]             = st_r.adcpre;
        cfg_rd[ccc_pkg::CFG_PB2_LO +: 3]              = st_r.pb2;
        cfg_rd[ccc_pkg::CFG_PB1_LO +: 3]              = st_r.pb1;
        cfg_rd[ccc_pkg::CFG_HB_LO +: 4]               = st_r.hb;
        cfg_rd[ccc_pkg::CFG_SWS_LO +: 2]              = st_r.sws;
        cfg_rd[ccc_pkg::CFG_SW_LO +: 2]               = st_r.sw;
        int_rd = '0;
        int_rd[ccc_pkg::INT_CSS_FLAG]                 = st_r.css_flag;
    end

    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.lock_s  = {st_r.lock_s[0], pll_locked_pin};
        st_nxt.fault_s = {st_r.fault_s[0], hse_fault_pin};
        st_nxt.nmi     = 1'b0;
        sw_req         = st_r.sw;

        // Calibration is caught once, the first cycle after release.
        if (!st_r.cal_done)
        begin
            st_nxt.cal      = cal_value;
            st_nxt.cal_done = 1'b1;
        end

        if (wr && hit_ctl)
        begin
            st_nxt.pll_en  = wdata[ccc_pkg::CTL_PLL_EN];
            st_nxt.hse_lp  = wdata[ccc_pkg::CTL_HSE_LP];
            st_nxt.css_en  = wdata[ccc_pkg::CTL_CSS_EN];
            // Bypass only latches with EXTERNAL_FAST_OSC off, protecting a running
            // crystal from a mode change underneath it.
            if (!st_r.hse_en)
            begin
                st_nxt.hse_byp = wdata[ccc_pkg::CTL_HSE_BYP];
            end
            st_nxt.hse_en  = wdata[ccc_pkg::CTL_HSE_EN];
            st_nxt.hsi_en  = wdata[ccc_pkg::CTL_HSI_EN];
            st_nxt.hsi_lp  = wdata[ccc_pkg::CTL_HSI_LP];
            if (wdata[ccc_pkg::CTL_HSI_LP] && !st_r.hsi_lp)
            begin
                st_nxt.trim = lp_trim_value;
            end
            else
            begin
                st_nxt.trim = wdata[ccc_pkg::CTL_TRIM_LO +: 5];
            end
        end

        if (wr && hit_cfg)
        begin
            st_nxt.adc_sel = wdata[ccc_pkg::CFG_ADC_SEL];
            st_nxt.duty    = wdata[ccc_pkg::CFG_DUTY_LO +: 3];
            st_nxt.mco     = wdata[ccc_pkg::CFG_MCO_LO +: 3];
            st_nxt.usb     = wdata[ccc_pkg::CFG_USB_LO +: 2];
            st_nxt.adcpre  = wdata[ccc_pkg::CFG_ADCP_LO +: 2];
            st_nxt.pb2     = wdata[ccc_pkg::CFG_PB2_LO +: 3];
            st_nxt.pb1     = wdata[ccc_pkg::CFG_PB1_LO +: 3];
            st_nxt.hb      = wdata[ccc_pkg::CFG_HB_LO +: 4];
            if (!st_r.pll_en)
            begin
                st_nxt.mul   = wdata[ccc_pkg::CFG_MUL_LO +: 4];
                st_nxt.xtpre = wdata[ccc_pkg::CFG_XTPRE];
                st_nxt.src   = wdata[ccc_pkg::CFG_SRC];
            end
            // Code 11 names no source and is dropped, keeping the old one.
            if (wdata[ccc_pkg::CFG_SW_LO +: 2] != 2'h3)
            begin
                st_nxt.sw = wdata[ccc_pkg::CFG_SW_LO +: 2];
                sw_req    = wdata[ccc_pkg::CFG_SW_LO +: 2];
            end
        end

        // A fault in the same cycle as the clear keeps the flag set.
        if (wr && hit_int && wdata[ccc_pkg::INT_CSS_CLR])
        begin
            st_nxt.css_flag = 1'b0;
        end

        if (hse_fail)
        begin
            st_nxt.css_flag = 1'b1;
            st_nxt.nmi      = !st_r.css_flag;
            st_nxt.hse_en   = 1'b0;
            if (hse_active)
            begin
                st_nxt.hsi_en = 1'b1;
                st_nxt.pll_en = 1'b0;
                st_nxt.sw     = ccc_pkg::SRC_HSI;
                st_nxt.sws    = ccc_pkg::SRC_HSI;
                sw_req        = ccc_pkg::SRC_HSI;
            end
        end

        if (lp_enter)
        begin
            st_nxt.pll_en = 1'b0;
            st_nxt.hse_en = 1'b0;
        end

        if (lp_exit)
        begin
            st_nxt.hsi_en = 1'b1;
            if (st_r.css_en)
            begin
                st_nxt.sw  = ccc_pkg::SRC_HSI;
                st_nxt.sws = ccc_pkg::SRC_HSI;
                sw_req     = ccc_pkg::SRC_HSI;
            end
        end

        // Except for the forced fault and wake fallbacks to INTERNAL_FAST_OSC, the system stays on the old source until the target is ready.
        unique case (sw_req)
            ccc_pkg::SRC_HSE: sw_target_rdy = hse_rdy;
            ccc_pkg::SRC_PLL: sw_target_rdy = pll_rdy;
            default:          sw_target_rdy = hsi_rdy;
        endcase
        if (sw_target_rdy && !hse_fail && !lp_exit)
        begin
            st_nxt.sws = sw_req;
        end

        st_nxt.rdata = '0;
        if (rd)
        begin
            if (hit_ctl)
            begin
                st_nxt.rdata = ctl_rd;
            end
            else if (hit_cfg)
            begin
                st_nxt.rdata = cfg_rd;
            end
            else if (hit_int)
            begin
                st_nxt.rdata = int_rd;
            end
        end

        st_nxt.tune    = 8'(st_nxt.cal + {3'h0, st_nxt.trim});
        st_nxt.hb_fac  = hb_factor(st_nxt.hb);
        st_nxt.pb1_fac = pb_factor(st_nxt.pb1);
        st_nxt.pb2_fac = pb_factor(st_nxt.pb2);
        st_nxt.adc_fac = 4'({1'b0, st_nxt.adcpre, 1'b0} + 4'h2);
        st_nxt.mul_fac = (st_nxt.mul == 4'hf) ? 5'h12
                                              : 5'({1'b0, st_nxt.mul} + 5'h2);
        unique case (st_nxt.usb)
            2'h1:    st_nxt.usb_x2 = 3'h4;
            2'h2:    st_nxt.usb_x2 = 3'h3;
            default: st_nxt.usb_x2 = 3'h2;
        endcase
        st_nxt.clkout  = clkout_onehot(st_nxt.mco);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r         <= '0;
            st_r.trim    <= ccc_pkg::TRIM_RST;
            st_r.hse_lp  <= ccc_pkg::HSE_LP_RST;
            st_r.hsi_en  <= ccc_pkg::HSI_EN_RST;
            st_r.hb_fac  <= 10'h001;
            st_r.pb1_fac <= 5'h01;
            st_r.pb2_fac <= 5'h01;
            st_r.adc_fac <= 4'h2;
            st_r.mul_fac <= 5'h02;
            st_r.usb_x2  <= 3'h2;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rdata                = st_r.rdata;
    assign pll_enable           = st_r.pll_en;
    assign ext_osc_enable       = st_r.hse_en;
    assign ext_clock_bypass     = st_r.hse_byp;
    assign ext_osc_low_power    = st_r.hse_lp;
    assign int_osc_enable       = st_r.hsi_en;
    assign int_osc_low_power    = st_r.hsi_lp;
    assign int_osc_tune         = st_r.tune;
    assign system_clock_source_status = st_r.sws;
    assign hb_div_factor        = st_r.hb_fac;
    assign pb1_div_factor       = st_r.pb1_fac;
    assign pb2_div_factor       = st_r.pb2_fac;
    assign adc_div_factor       = st_r.adc_fac;
    assign adc_from_hclk        = st_r.adc_sel;
    assign adc_duty_extra       = st_r.duty;
    assign pll_mult_factor      = st_r.mul_fac;
    assign pll_from_ext         = st_r.src;
    assign pll_ext_halve        = st_r.xtpre;
    assign usb_div_x2           = st_r.usb_x2;
    assign clkout_sel           = st_r.clkout;
    assign clock_security_flag  = st_r.css_flag;
    assign nmi_req              = st_r.nmi;
endmodule

// >>> verif/ccc_core_properties.sv
`timescale 1ns/1ps
module ccc_props
(
    input wire logic        clk,                  // System clock.
    input wire logic        rstn,                 // Reset, active low.
    input wire logic [31:0] addr,                 // Register address.
    input wire logic [31:0] wdata,                // Write data.
    input wire logic        wr,                   // Write strobe.
    input wire logic        lp_enter,             // Sleep entry.
    input wire logic        lp_exit,              // Wake.
    input wire logic        pll_enable,           // PLL run.
    input wire logic        ext_osc_enable,       // EXTERNAL_FAST_OSC run.
    input wire logic        int_osc_enable,       // INTERNAL_FAST_OSC run.
    input wire logic [1:0]  system_clock_source_status, // Active source.
    input wire logic [3:0]  clkout_sel,           // Clock output.
    input wire logic [4:0]  pll_mult_factor,      // PLL factor.
    input wire logic        clock_security_flag,  // Fault flag.
    input wire logic        nmi_req               // NMI pulse.
);
    default clocking
        @(posedge clk);
    endclocking
    default disable iff (!rstn);
    lp_off_a: assert property (lp_enter |=>
        !pll_enable && !ext_osc_enable)
        else $error("oscillator left running after sleep entry");
    wake_hsi_a: assert property (lp_exit |=> int_osc_enable)
        else $error("INTERNAL_FAST_OSC not restarted on wake");
    nmi_flag_a: assert property ($rose(clock_security_flag) |-> nmi_req)
        else $error("flag rose without NMI");
    nmi_cause_a: assert property (nmi_req |-> clock_security_flag
        && !$past(clock_security_flag)) else $error("NMI without new flag");
    fault_sw_a: assert property ($rose(clock_security_flag)
        && $past(system_clock_source_status) == ccc_pkg::SRC_HSE
        |-> system_clock_source_status == ccc_pkg::SRC_HSI && int_osc_enable
        && !ext_osc_enable) else $error("no fallback to INTERNAL_FAST_OSC on fault");
    mul_lock_a: assert property ($past(pll_enable) |->
        $stable(pll_mult_factor)) else $error("PLL factor moved while on");
    sws_legal_a: assert property (system_clock_source_status != 2'h3)
        else $error("status shows unavailable source");
    mco_map_a: assert property (wr && addr == ccc_pkg::ADDR_CFG0 |=>
        clkout_sel == ($past(wdata[26]) ? 4'h1 << $past(wdata[25:24]) : 4'h0))
        else $error("clock output select mismatch");
endmodule
bind ccc_core ccc_props ccc_props_i (.*);

// >>> verif/ccc_core_test.sv
`timescale 1ns/1ps
module ccc_core_test;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0, lp_enter = 0, lp_exit = 0;
    logic        pll_locked_pin = 0, hse_fault_pin = 0, hsi_stable_pin = 1;
    logic        hsi_clk_pin = 0, hse_stable_pin = 1, hse_clk_pin = 0;
    logic [31:0] addr = 0, wdata = 0, rdata;
    logic [7:0]  cal_value = 8'h5a, int_osc_tune;
    logic [4:0]  lp_trim_value = 5'h03, pb1_div_factor, pb2_div_factor;
    logic        pll_enable, ext_osc_enable, ext_clock_bypass, nmi_req;
    logic        ext_osc_low_power, int_osc_enable, int_osc_low_power;
    logic [1:0]  system_clock_source_status;
    logic [9:0]  hb_div_factor;
    logic [4:0]  pll_mult_factor;
    logic [3:0]  adc_div_factor, clkout_sel;
    logic        adc_from_hclk, pll_from_ext, pll_ext_halve;
    logic [2:0]  adc_duty_extra, usb_div_x2;
    logic        clock_security_flag;
    logic [9:0]  hb_tab [8] = '{2, 4, 8, 16, 64, 128, 1, 512};
    int          miscompares = 0;
    int          n_compared = 0;
    ccc_core ccc_core_i (.*);
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Oscillators run at half the system rate so ready-drop counts stay short.
    always @(posedge clk)
    begin
        hsi_clk_pin <= ~hsi_clk_pin;
        hse_clk_pin <= ~hse_clk_pin;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic sleep(input logic wake);
        @(posedge clk);
        lp_enter <= !wake;
        lp_exit <= wake;
        @(posedge clk);
        lp_enter <= 1'b0;
        lp_exit <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        miscompares++;
        finish_test;
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0010_5a83);
        check(32'(int_osc_tune), 32'h6a);
        rd_reg(ccc_pkg::ADDR_CFG0, 32'h0);
        rd_reg(32'h4002_1030, 32'h0);
        wr_reg(ccc_pkg::ADDR_CTL, 32'h00e0_0041);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0000_5a43);
        check(32'(int_osc_tune), 32'h62);
        wr_reg(ccc_pkg::ADDR_CTL, 32'h0000_0045);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0000_5a1f);
        check(32'({ext_osc_low_power, int_osc_low_power}), 32'h1);
        $display("test reset and trim done");
        wr_reg(ccc_pkg::ADDR_CFG0, 32'h2);
        wr_reg(ccc_pkg::ADDR_CTL, 32'h0009_0001);
        repeat (8) @(posedge clk);
        #1;
        check(32'(system_clock_source_status), 32'h0);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h000b_5a03);
        wr_reg(ccc_pkg::ADDR_CFG0, 32'h1);
        check(32'(system_clock_source_status), 32'h1);
        @(posedge clk);
        hse_fault_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(32'({clock_security_flag, ext_osc_enable, int_osc_enable,
            system_clock_source_status, nmi_req}), 32'h28);
        rd_reg(ccc_pkg::ADDR_INT, 32'h80);
        @(posedge clk);
        hse_fault_pin <= 1'b0;
        repeat (4) @(posedge clk);
        wr_reg(ccc_pkg::ADDR_INT, 32'h0080_0000);
        rd_reg(ccc_pkg::ADDR_INT, 32'h0);
        $display("test security done");
        wr_reg(ccc_pkg::ADDR_CFG0, 32'hd0bf_f500);
        check(32'(pll_mult_factor), 32'd18);
        check(32'({hb_div_factor, usb_div_x2, adc_div_factor, pb2_div_factor,
            pb1_div_factor}), 32'h0002_e104);
        check(32'({adc_from_hclk, adc_duty_extra, pll_from_ext,
            pll_ext_halve}), 32'h37);
        @(posedge clk);
        pll_locked_pin <= 1'b1;
        wr_reg(ccc_pkg::ADDR_CTL, 32'h0004_0001);
        wr_reg(ccc_pkg::ADDR_CTL, 32'h0105_0001);
        repeat (4) @(posedge clk);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0307_5a03);
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(ccc_pkg::ADDR_CFG0, 32'(i) << 24 | 32'(i + 8) << 4);
            check(32'({pll_from_ext, pll_ext_halve, pll_mult_factor}),
                32'h72);
            check(32'(clkout_sel), i < 4 ? 32'h0 : 32'h1 << (i - 4));
            check(32'(hb_div_factor), 32'(hb_tab[i]));
        end
        $display("test pll and dividers done");
        sleep(1'b0);
        check(32'({pll_enable, ext_osc_enable, ext_clock_bypass}),
            32'h1);
        wr_reg(ccc_pkg::ADDR_CTL, 32'h0);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0202_5a02);
        repeat (20) @(posedge clk);
        rd_reg(ccc_pkg::ADDR_CTL, 32'h0200_5a00);
        sleep(1'b1);
        check(32'(int_osc_enable), 32'h1);
        $display("test sleep done");
        finish_test;
    end
endmodule
